//--- shared/cfg_bank_consts.svh
`ifndef CFG_BANK_CONSTS_SVH
`define CFG_BANK_CONSTS_SVH
`define IO_WIN_LO 16'hfc80
`define IO_WIN_HI 16'hfc89
`define OFF_BUS_CTRL 16'hfc80
`define OFF_MEM_CFG1 16'hfc81
`define OFF_MEM_STRAP 16'hfc82
`define OFF_UNLOCK 16'hfc87
`define RST_BUS_CTRL 8'h32
`define RST_MEM_CFG1 8'h00
`define RST_STRAP 8'h00
`define RST_WAIT8 3'h4
`define RST_WAIT16 3'h1
`define RST_WAITROM 3'h3
`define RST_DRAM_WAIT 1'b1
`define WAIT8_BASE 3'h5
`define WAIT16_BASE 3'h3
`define WAITROM_BASE 3'h3
`define MASK_BUS_CTRL 8'h7f
`define MASK_STRAP 8'hf1
`define RAS_TIMEOUT_NS 10000
`define CLK_PERIOD_NS 100
`define RAS_TIMEOUT_CYC (`RAS_TIMEOUT_NS / `CLK_PERIOD_NS)
`endif

//--- shared/cfg_bank_pkg.sv
package cfg_bank_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] io_addr_t;
  typedef enum logic [1:0] {
    ck_full,
    ck_half,
    ck_quarter,
    ck_alt_half
  } clk_sel_e;
  typedef logic [2:0] wait_t;
endpackage : cfg_bank_pkg

//--- hdl/strap_sync.sv
module strap_sync (
  input wire logic mclk,
  input wire logic [4:0] strap_pins,
  output logic [4:0] strap_sync_q
);
  logic [4:0] meta_ff;
  logic [4:0] sync_ff;
  always_ff @(posedge mclk) begin
    meta_ff <= strap_pins;
    sync_ff <= meta_ff;
  end
  assign strap_sync_q = sync_ff;
endmodule : strap_sync

//--- hdl/clock_gen.sv
`include "cfg_bank_consts.svh"
module clock_gen
  import cfg_bank_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] clk_sel,
  input wire logic alt_tick,
  output logic cpu_clock_out,
  output logic expansion_bus_clock_out
);
  // Enables derived from mclk stand in for the input clock
  logic [2:0] div_ff, nxt_div;
  logic [2:0] sel_ff, nxt_sel;
  logic cpu_ff, nxt_cpu;
  logic bus_ff, nxt_bus;
  logic alt_ff, nxt_alt;
  always_comb begin
    nxt_div = div_ff + 3'h1;
    nxt_sel = sel_ff;
    nxt_alt = alt_tick ? ~alt_ff : alt_ff;
    // Select changes only at the divider wrap, so divider-based outputs restart a whole phase; the select-7 bus clock follows alt_ff
    if (div_ff == 3'h7) begin
      nxt_sel = clk_sel;
    end
    nxt_cpu = sel_ff[2] ? div_ff[0] : div_ff[1];
    case (sel_ff)
      3'h5: nxt_bus = div_ff[1];
      3'h6: nxt_bus = div_ff[2];
      3'h7: nxt_bus = alt_ff;
      default: nxt_bus = div_ff[2];
    endcase
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_ff <= 3'h0;
      sel_ff <= 3'b000;
      cpu_ff <= 1'b0;
      bus_ff <= 1'b0;
      alt_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      sel_ff <= nxt_sel;
      cpu_ff <= nxt_cpu;
      bus_ff <= nxt_bus;
      alt_ff <= nxt_alt;
    end
  end
  assign cpu_clock_out = cpu_ff;
  assign expansion_bus_clock_out = bus_ff;
endmodule : clock_gen

//--- hdl/config_register_bank.sv
// Behaviour
// [RL1] Reserved bits read zero, ignore writes
// [RL2] Decode IO window FC80h to FC89h
// [RL3] Access to FC87h sets unlock flag
// [RL4] Reset or next access clears flag
// [RL5] Locked accesses denied, writes ignored
// [RL6] Bits 6-5 give 8-bit waits 5..2
// [RL7] Bits 4-3 give 16-bit waits 3..0
// [RL8] Bits 2-0 select cpu/bus clocks
// [RL9] Clock switch without glitches
// [RL10] Config1 bit7 selects page interleave
// [RL11] Relocation bit remaps BIOS-area DRAM
// [RL12] Software keeps relocation off when unsafe
// [RL13] Bits 5-3 select bank organisation
// [RL14] Bit2 zero adds one DRAM wait
// [RL15] Bits 1-0 give ROM waits 3..0
// [RL16] Shadowed BIOS uses DRAM wait setting
// [RL17] Straps sampled into bits 7-4,0 at reset
// [RL18] Strap register read only until reset
// [RL19] Strap7 advanced interleave, page mode only
// [RL20] Strap6 selects 8-bit BIOS ROM
// [RL21] Strap5 zero limits row strobe to 10us
// [RL22] Conventional mode releases row strobe each access
`include "cfg_bank_consts.svh"
module config_register_bank
  import cfg_bank_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire cfg_bank_pkg::io_addr_t io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic mem_access,
  input wire cfg_bank_pkg::byte_t io_wdata,
  input wire logic dma_ack_ch6_strap,
  input wire logic dma_ack_ch5_strap,
  input wire logic dma_ack_ch3_strap,
  input wire logic dma_ack_ch2_strap,
  input wire logic dma_ack_ch0_strap,
  input wire logic alt_bus_tick,
  input wire logic bios_shadowed,
  input wire logic row_active,
  input wire logic mem_cycle_end,
  output cfg_bank_pkg::byte_t io_rdata,
  output logic io_rdata_valid,
  output logic cpu_clock_out,
  output logic expansion_bus_clock_out,
  output cfg_bank_pkg::wait_t wait_8bit,
  output cfg_bank_pkg::wait_t wait_16bit,
  output cfg_bank_pkg::wait_t wait_rom,
  output logic dram_wait,
  output logic page_interleave,
  output logic advanced_interleave,
  output logic relocate_bios_ram,
  output logic [2:0] bank_org,
  output logic rom_8bit,
  output logic ras_release
);
  import cfg_bank_pkg::*;

  // Last count before the row strobe time-out, cut to the counter width
  localparam logic [6:0] ras_last = 7'(`RAS_TIMEOUT_CYC - 1);

  // Each code step removes one wait from the base count
  function automatic wait_t waits_of(input logic [1:0] code, input logic [2:0] base);
    waits_of = base - {1'b0, code};
  endfunction : waits_of

  function automatic logic addr_is(input io_addr_t addr, input io_addr_t off);
    addr_is = (addr == off);
  endfunction : addr_is

  // Strap pins land in bits 7-4 and bit 0; bits 3-1 are hardwired low
  function automatic byte_t strap_pack(input logic [4:0] pins);
    strap_pack = {pins[4:1], 3'h0, pins[0]} & `MASK_STRAP;
  endfunction : strap_pack

  // Row strobe has stood for the whole page-mode time-out
  function automatic logic ras_expired(input logic [6:0] cnt);
    ras_expired = (cnt >= ras_last);
  endfunction : ras_expired

  logic [4:0] strap_q;
  logic strap_take_ff, nxt_strap_take;
  logic unlock_ff, nxt_unlock;
  byte_t bus_ctrl_ff, nxt_bus_ctrl;
  byte_t cfg1_ff, nxt_cfg1;
  byte_t strap_ff, nxt_strap;
  byte_t rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  wait_t w8_ff, w16_ff, wrom_ff;
  wait_t nxt_w8, nxt_w16, nxt_wrom;
  logic dw_ff, pi_ff, ai_ff, rel_ff, r8_ff, rr_ff;
  logic nxt_dw, nxt_pi, nxt_ai, nxt_rel, nxt_r8, nxt_rr;
  logic [2:0] org_ff, nxt_org;
  logic [6:0] ras_cnt_ff, nxt_ras_cnt;
  logic in_win, is_unlock, any_acc, granted;

  // Straps are pins: two flip-flops before any logic reads them
  strap_sync u_strap_sync (
    .mclk(mclk),
    .strap_pins({dma_ack_ch6_strap, dma_ack_ch5_strap, dma_ack_ch3_strap,
                 dma_ack_ch2_strap, dma_ack_ch0_strap}),
    .strap_sync_q(strap_q)
  );

  // Clock outputs are enable-rate divisions of mclk, except the select-7 bus clock, which follows alt_bus_tick
  clock_gen u_clock_gen (
    .mclk(mclk),
    .rst(rst),
    .clk_sel(bus_ctrl_ff[2:0]),
    .alt_tick(alt_bus_tick),
    .cpu_clock_out(cpu_clock_out),
    .expansion_bus_clock_out(expansion_bus_clock_out)
  ); // [RL8] [RL9]

  // Unlock flag: set by an access to the unlock address, cleared by the next access
  always_comb begin
    in_win = (io_addr >= `IO_WIN_LO) && (io_addr <= `IO_WIN_HI); // [RL2]
    is_unlock = in_win && addr_is(io_addr, `OFF_UNLOCK);
    any_acc = io_rd || io_wr || mem_access;
    granted = unlock_ff && in_win && !is_unlock; // [RL5]
    nxt_unlock = unlock_ff;
    if (any_acc) begin
      nxt_unlock = (io_rd || io_wr) && is_unlock; // [RL3] [RL4]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      unlock_ff <= 1'b0;
    end else begin
      unlock_ff <= nxt_unlock;
    end
  end

  // Writable registers take data only on a granted write
  always_comb begin
    nxt_bus_ctrl = bus_ctrl_ff;
    nxt_cfg1 = cfg1_ff;
    if (io_wr && granted) begin
      if (addr_is(io_addr, `OFF_BUS_CTRL)) begin
        nxt_bus_ctrl = io_wdata & `MASK_BUS_CTRL; // [RL1]
      end
      if (addr_is(io_addr, `OFF_MEM_CFG1)) begin
        nxt_cfg1 = io_wdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_ctrl_ff <= `RST_BUS_CTRL;
      cfg1_ff <= `RST_MEM_CFG1;
    end else begin
      bus_ctrl_ff <= nxt_bus_ctrl;
      cfg1_ff <= nxt_cfg1;
    end
  end

  // Strap register is loaded only just after reset, never by writes
  always_comb begin
    nxt_strap_take = 1'b0;
    nxt_strap = strap_ff;
    if (strap_take_ff) begin
      nxt_strap = strap_pack(strap_q); // [RL17] [RL18]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      strap_take_ff <= 1'b1;
      strap_ff <= `RST_STRAP;
    end else begin
      strap_take_ff <= nxt_strap_take;
      strap_ff <= nxt_strap;
    end
  end

  // Read data stand for one cycle; unused window addresses read zero
  always_comb begin
    nxt_rdata = 8'h00;
    nxt_rvalid = 1'b0;
    if (io_rd && granted) begin
      nxt_rvalid = 1'b1;
      case (io_addr)
        `OFF_BUS_CTRL: nxt_rdata = bus_ctrl_ff;
        `OFF_MEM_CFG1: nxt_rdata = cfg1_ff;
        `OFF_MEM_STRAP: nxt_rdata = strap_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // Expansion bus wait counts
  always_comb begin
    nxt_w8 = waits_of(bus_ctrl_ff[6:5], `WAIT8_BASE); // [RL6]
    nxt_w16 = waits_of(bus_ctrl_ff[4:3], `WAIT16_BASE); // [RL7]
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      w8_ff <= `RST_WAIT8;
      w16_ff <= `RST_WAIT16;
    end else begin
      w8_ff <= nxt_w8;
      w16_ff <= nxt_w16;
    end
  end

  // Memory settings, registered so every output comes from a flip-flop
  always_comb begin
    nxt_wrom = waits_of(cfg1_ff[1:0], `WAITROM_BASE); // [RL15]
    if (bios_shadowed) begin
      nxt_wrom = {2'h0, ~cfg1_ff[2]}; // [RL16]
    end
    nxt_dw = ~cfg1_ff[2]; // [RL14]
    nxt_pi = cfg1_ff[7]; // [RL10]
    nxt_ai = cfg1_ff[7] & strap_ff[7]; // [RL19]
    nxt_rel = cfg1_ff[6]; // [RL11]
    nxt_org = cfg1_ff[5:3]; // [RL13]
    nxt_r8 = strap_ff[6]; // [RL20]
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrom_ff <= `RST_WAITROM;
      dw_ff <= `RST_DRAM_WAIT;
      pi_ff <= 1'b0;
      ai_ff <= 1'b0;
      rel_ff <= 1'b0;
      org_ff <= 3'h0;
      r8_ff <= 1'b0;
    end else begin
      wrom_ff <= nxt_wrom;
      dw_ff <= nxt_dw;
      pi_ff <= nxt_pi;
      ai_ff <= nxt_ai;
      rel_ff <= nxt_rel;
      org_ff <= nxt_org;
      r8_ff <= nxt_r8;
    end
  end

  // Row strobe counter saturates so a long page keeps the release asserted
  always_comb begin
    nxt_ras_cnt = 7'h00;
    if (row_active) begin
      nxt_ras_cnt = (ras_cnt_ff == 7'h7f) ? ras_cnt_ff : ras_cnt_ff + 7'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ras_cnt_ff <= 7'h00;
    end else begin
      ras_cnt_ff <= nxt_ras_cnt;
    end
  end

  // Row strobe release: every access in conventional mode, time-out in page mode only while strap bit 5 is low
  always_comb begin
    nxt_rr = 1'b0;
    if (!cfg1_ff[7]) begin
      nxt_rr = mem_cycle_end; // [RL22]
    end else if (!strap_ff[5] && row_active && ras_expired(ras_cnt_ff)) begin
      nxt_rr = 1'b1; // [RL21]
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rr_ff <= 1'b0;
    end else begin
      rr_ff <= nxt_rr;
    end
  end

  assign io_rdata = rdata_ff;
  assign io_rdata_valid = rvalid_ff;
  assign wait_8bit = w8_ff;
  assign wait_16bit = w16_ff;
  assign wait_rom = wrom_ff;
  assign dram_wait = dw_ff;
  assign page_interleave = pi_ff;
  assign advanced_interleave = ai_ff;
  assign relocate_bios_ram = rel_ff;
  assign bank_org = org_ff;
  assign rom_8bit = r8_ff;
  assign ras_release = rr_ff;
endmodule : config_register_bank

//--- bench/config_register_bank_monitor.sv
module config_register_bank_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic mem_access,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rdata_valid,
  input wire logic [2:0] wait_8bit,
  input wire logic [2:0] wait_16bit,
  input wire logic dram_wait,
  input wire logic page_interleave
);
  timeunit 1ns;
  timeprecision 1ns;
  logic unl_ff;
  logic win;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  assign win = io_addr >= 16'hfc80 && io_addr <= 16'hfc89;
  // Shadow of the one-shot unlock flag
  always_ff @(posedge mclk) begin
    unl_ff <= rst ? 1'b0 : (io_rd || io_wr) ? io_addr == 16'hfc87 : unl_ff && !mem_access;
  end
  sequence rd_ok;
    io_rd && unl_ff && win && io_addr != 16'hfc87;
  endsequence
  sequence wr_bus;
    io_wr && unl_ff && io_addr == 16'hfc80;
  endsequence
  a_locked_read: assert property (io_rd && win && !unl_ff |=> !io_rdata_valid)
    else $error("locked read answered");
  a_granted_read: assert property (rd_ok |=> io_rdata_valid)
    else $error("granted read silent");
  a_unlock_silent: assert property (io_rd && io_addr == 16'hfc87 |=> !io_rdata_valid)
    else $error("unlock read answered");
  a_valid_pulse: assert property (io_rdata_valid |=> !io_rdata_valid)
    else $error("valid too long");
  a_reserved_zero: assert property (rd_ok ##0 io_addr == 16'hfc80 |=> !io_rdata[7])
    else $error("reserved bit set");
  a_wait8_code: assert property (wr_bus |-> ##3 wait_8bit == 3'd5 - $past(io_wdata[6:5], 3))
    else $error("bad 8-bit waits");
  a_wait16_code: assert property (wr_bus |-> ##3 wait_16bit == 3'd3 - $past(io_wdata[4:3], 3))
    else $error("bad 16-bit waits");
  a_mem_mode: assert property (io_wr && unl_ff && io_addr == 16'hfc81 |-> ##3
    dram_wait == !$past(io_wdata[2], 3) && page_interleave == $past(io_wdata[7], 3))
    else $error("bad memory mode");
endmodule : config_register_bank_monitor

bind config_register_bank config_register_bank_monitor mon_u (.*);

//--- bench/config_register_bank_tb.sv
module config_register_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, io_rd = 0, io_wr = 0, mem_access = 0, alt_bus_tick = 0;
  logic bios_shadowed = 0, row_active = 0, mem_cycle_end = 0, rd_seen, io_rdata_valid;
  logic cpu_clock_out, expansion_bus_clock_out, dram_wait, page_interleave, ras_release;
  logic advanced_interleave, relocate_bios_ram, rom_8bit;
  logic [15:0] io_addr = 0;
  logic [7:0] io_wdata = 0, io_rdata, rd_data, d;
  logic [4:0] strap = 5'h13;
  logic [2:0] wait_8bit, wait_16bit, wait_rom, bank_org;
  int err_count = 0, samples_checked = 0, n;
  config_register_bank dut_u (.dma_ack_ch6_strap(strap[4]), .dma_ack_ch5_strap(strap[3]),
    .dma_ack_ch3_strap(strap[2]), .dma_ack_ch2_strap(strap[1]), .dma_ack_ch0_strap(strap[0]), .*);
  always #50 mclk = ~mclk;
  always @(negedge mclk) alt_bus_tick <= ~alt_bus_tick;
  always @(posedge mclk) if (io_rdata_valid === 1'b1) {rd_seen, rd_data} <= {1'b1, io_rdata};
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Counts rising edges of both clock outputs over 16 mclk cycles
  task automatic clk_rises(input logic [3:0] ce, input logic [3:0] be);
    logic pc, pb;
    logic [3:0] nc, nb;
    repeat (2) @(negedge mclk);
    {pc, pb, nc, nb} = {cpu_clock_out, expansion_bus_clock_out, 8'h00};
    repeat (16) begin
      @(negedge mclk);
      nc = nc + 4'(cpu_clock_out === 1'b1 && pc === 1'b0);
      nb = nb + 4'(expansion_bus_clock_out === 1'b1 && pb === 1'b0);
      {pc, pb} = {cpu_clock_out, expansion_bus_clock_out};
    end
    chk({nc, nb}, {ce, be});
  endtask : clk_rises
  task automatic acc(input logic r, input logic [15:0] a, input logic [7:0] wd);
    @(negedge mclk);
    {io_rd, io_wr, io_addr, io_wdata} = {r, !r, a, wd};
    @(negedge mclk);
    {io_rd, io_wr} = 2'b00;
  endtask : acc
  task automatic wr(input logic [15:0] a, input logic [7:0] wd, input logic u);
    if (u) acc(0, 16'hfc87, 8'h00);
    acc(0, a, wd);
    repeat (3) @(negedge mclk);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic u, input logic v, input logic [7:0] e);
    if (u) acc(1, 16'hfc87, 8'h00);
    rd_seen = 0;
    acc(1, a, 8'h00);
    repeat (2) @(negedge mclk);
    chk({rd_seen, v ? rd_data : 8'h00}, {v, e});
  endtask : rd
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  initial begin
    #(5000 * 100);
    err_count++;
    summarize();
  end
  initial begin
    repeat (2) @(negedge mclk);
    rst = 0;
    @(negedge mclk);
    chk({wait_8bit, wait_16bit, wait_rom, dram_wait}, {3'd4, 3'd1, 3'd3, 1'b1});
    rd(16'hfc80, 1, 1, 8'h32);
    rd(16'hfc82, 1, 1, 8'h91);
    strap = 5'h0c;
    wr(16'hfc82, 8'hff, 1);
    rd(16'hfc82, 1, 1, 8'h91);
    $display("test reset and straps done");
    wr(16'hfc80, 8'h00, 0);
    rd(16'hfc80, 0, 0, 8'h00);
    rd(16'hfc80, 1, 1, 8'h32);
    acc(1, 16'hfc87, 8'h00);
    mem_access = 1;
    @(negedge mclk);
    mem_access = 0;
    rd(16'hfc80, 0, 0, 8'h00);
    rd(16'hfc89, 1, 1, 8'h00);
    rd(16'hfc8a, 1, 0, 8'h00);
    $display("test lock done");
    for (int i = 0; i < 4; i++) begin
      d = 8'h80 | 8'(i << 5) | 8'(i << 3) | (i == 0 ? 8'h00 : 8'(4 + i));
      wr(16'hfc80, d, 1);
      chk({wait_8bit, wait_16bit}, {3'(5 - i), 3'(3 - i)});
      rd(16'hfc80, 1, 1, d & 8'h7f);
      clk_rises(i == 0 ? 4'h4 : 4'h8, i[0] ? 4'h4 : 4'h2);
    end
    for (int i = 0; i < 4; i++) begin
      d = {i[0], 1'b0, 3'(i + 4), i[1], 2'(i)};
      wr(16'hfc81, d, 1);
      chk({wait_rom, dram_wait, page_interleave, bank_org},
        {3'(3 - i), !i[1], i[0], 3'(i + 4)});
    end
    bios_shadowed = 1;
    repeat (3) @(negedge mclk);
    chk({wait_rom, advanced_interleave, rom_8bit}, 5'h02);
    row_active = 1;
    for (n = 0; n < 200 && ras_release !== 1'b1; n++) @(negedge mclk);
    chk(n >= 95 && n <= 105, 1);
    row_active = 0;
    wr(16'hfc81, 8'h40, 1);
    chk({relocate_bios_ram, page_interleave}, 2'h2);
    mem_cycle_end = 1;
    @(negedge mclk);
    mem_cycle_end = 0;
    chk(ras_release, 1);
    @(negedge mclk);
    chk(ras_release, 0);
    $display("test settings done");
    rst = 1;
    repeat (2) @(negedge mclk);
    rst = 0;
    @(negedge mclk);
    chk({wait_8bit, wait_16bit, relocate_bios_ram}, {3'h4, 3'h1, 1'b0});
    rd(16'hfc82, 1, 1, 8'h60);
    chk(rom_8bit, 1);
    wr(16'hfc81, 8'h80, 1);
    chk(advanced_interleave, 0);
    row_active = 1;
    for (n = 0; n < 150 && ras_release !== 1'b1; n++) @(negedge mclk);
    row_active = 0;
    chk(16'(n), 16'h0096);
    $display("test second reset done");
    summarize();
  end
endmodule : config_register_bank_tb
